// file: core/msim_pkg.sv
// package of the status, mask and buffer-credit block
// assumes word-addressed register offsets from the control-command decoder
package msim_pkg;

    // ------------------------------------------------------------
    // register word offsets
    // ------------------------------------------------------------
    localparam logic [7:0]  ADDR_STATUS_MAIN   = 8'h08;
    localparam logic [7:0]  ADDR_VENDOR_STATUS = 8'h09;
    localparam logic [7:0]  ADDR_BUFFER_CREDIT = 8'h0B;
    localparam logic [7:0]  ADDR_MASK_MAIN     = 8'h0C;
    localparam logic [7:0]  ADDR_MASK_VENDOR   = 8'h0D;

    // ------------------------------------------------------------
    // main event flag positions
    // ------------------------------------------------------------
    localparam int          FLAG_W             = 13;
    localparam int          BIT_TX_PROTO       = 0;
    localparam int          BIT_TX_OVERFLOW    = 1;
    localparam int          BIT_TX_UNDERFLOW   = 2;
    localparam int          BIT_RX_OVERFLOW    = 3;
    localparam int          BIT_FRAMING_LOSS   = 4;
    localparam int          BIT_HEADER_PARITY  = 5;
    localparam int          BIT_RESET_DONE     = 6;
    localparam int          BIT_PHY_SERVICE    = 7;
    localparam int          BIT_STAMP_A        = 8;
    localparam int          BIT_STAMP_B        = 9;
    localparam int          BIT_STAMP_C        = 10;
    localparam int          BIT_TX_CHECKSUM    = 11;
    localparam int          BIT_CTRL_PROTECT   = 12;

    // ------------------------------------------------------------
    // reset values and field layout
    // ------------------------------------------------------------
    localparam logic [12:0] STATUS_MAIN_RST    = 13'h0040;
    localparam logic [12:0] MASK_MAIN_RST      = 13'h1FBF;
    localparam logic [12:0] MASK_MAIN_WRITABLE = 13'h1FBF;
    localparam logic [31:0] VENDOR_RST         = 32'h0000_0000;
    localparam logic [31:0] VMASK_RST          = 32'h0000_0000;
    localparam logic [7:0]  COUNT_RST          = 8'h00;
    localparam logic [7:0]  COUNT_SAT          = 8'h1F;
    localparam int          CREDIT_LSB         = 8;

    // footer fields sent to the host in every receive chunk
    typedef struct packed {
        logic       ext;
        logic [4:0] credit;
        logic [4:0] chunk;
    } msim_footer_s;

endpackage

// file: core/msim_status_irq.sv
// event flags, masks, credit counts and footer/interrupt outputs
// assumes the command decoder gives one-cycle register strobes on clock,
// and the link-side logic gives one-cycle event strobes on link_clk
`timescale 1ns/1ps
module msim_status_irq
    import msim_pkg::*;
#(
    parameter bit HAS_PROTECT  = 1'b1,
    parameter bit HAS_CHECKSUM = 1'b1,
    parameter bit HAS_STAMP    = 1'b1,
    parameter bit HAS_PHY_IRQ  = 1'b1,
    parameter int CNT_W        = 8
) (
    input  wire logic               clock,
    input  wire logic               srst,
    // register port from the control-command decoder
    input  wire logic               reg_wr,
    input  wire logic               reg_rd,
    input  wire logic [7:0]         reg_addr,
    input  wire logic [31:0]        reg_wdata,
    output logic [31:0]             reg_rdata,
    output logic                    reg_rvalid,
    // internal event sources, same clock
    input  wire logic               ctrl_protect_enable,
    input  wire logic               tx_checksum_bad,
    input  wire logic               egress_stamp_a,
    input  wire logic               egress_stamp_b,
    input  wire logic               egress_stamp_c,
    input  wire logic               phy_service_req,
    input  wire logic               rx_overflow_evt,
    input  wire logic               tx_underflow_evt,
    input  wire logic               tx_overflow_evt,
    input  wire logic               tx_proto_evt,
    input  wire logic [31:0]        vendor_src,
    input  wire logic [CNT_W-1:0]   tx_credit_raw,
    input  wire logic [CNT_W-1:0]   rx_chunk_raw,
    output logic                    irq_out_n,
    // link-side domain
    input  wire logic               link_clk,
    input  wire logic               link_srst,
    input  wire logic               link_hdr_parity_err,
    input  wire logic               link_cs_early_release,
    input  wire logic               link_ctrl_valid,
    input  wire logic [31:0]        link_ctrl_word,
    input  wire logic [31:0]        link_ctrl_compl,
    input  wire logic [31:0]        link_rd_word,
    output logic [31:0]             link_tx_word,
    output logic [31:0]             link_tx_compl,
    output msim_footer_s            link_footer
);

    // ------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------
    if (CNT_W < 5 || CNT_W > 8) begin : g_bad_cnt
        $error("CNT_W must lie between 5 and 8");
    end

    // ------------------------------------------------------------
    // state of both domains
    // ------------------------------------------------------------
    typedef struct packed {
        logic [12:0]  status;
        logic [31:0]  vstatus;
        logic [12:0]  mask;
        logic [31:0]  vmask;
        logic [12:0]  src_prev;
        logic [31:0]  vsrc_prev;
        logic [7:0]   tx_credit_count;
        logic [7:0]   rx_chunk_count;
        logic         prot;
        logic         irq_n;
        logic         ext;
        logic [2:0]   hdr_sync;
        logic [2:0]   framing_loss_err_sync;
        logic [2:0]   ctrl_protect_err_sync;
        logic         ack_s1;
        logic         ack_s2;
        logic         req;
        msim_footer_s hold;
        logic         rvalid;
        logic [31:0]  rdata;
    } msim_core_s;

    typedef struct packed {
        logic         req_s1;
        logic         req_s2;
        logic         ack;
        logic         prot_s1;
        logic         prot_s2;
        logic         hdr_tgl;
        logic         framing_loss_err_tgl;
        logic         ctrl_protect_err_tgl;
        msim_footer_s footer;
        logic [31:0]  tx_word;
        logic [31:0]  tx_compl;
    } msim_link_s;

    msim_core_s c;
    msim_core_s next_c;
    msim_link_s l;
    msim_link_s next_l;

    logic [12:0] impl;
    logic [12:0] src_now;
    logic [12:0] set_main;
    logic [12:0] clr_main;
    logic [31:0] set_vendor;
    logic [31:0] clr_vendor;
    logic        prot_bad;

    // saturate a raw count at 31
    function automatic logic [7:0] sat5(input logic [CNT_W-1:0] raw);
        logic [7:0] wide;
        wide = 8'(raw);
        sat5 = (wide > COUNT_SAT) ? COUNT_SAT : wide;
    endfunction

    // ------------------------------------------------------------
    // event sources and write-one-clear terms
    // ------------------------------------------------------------
    // absent features are masked out here so their flags stay at zero
    assign impl = {HAS_PROTECT, HAS_CHECKSUM, {3{HAS_STAMP}}, HAS_PHY_IRQ, 7'h7F};

    // link events arrive as toggles; stage 1 vs 2 marks one event
    always_comb begin
        src_now                    = 13'h0000;
        src_now[BIT_TX_PROTO]      = tx_proto_evt;
        src_now[BIT_TX_OVERFLOW]   = tx_overflow_evt;
        src_now[BIT_TX_UNDERFLOW]  = tx_underflow_evt;
        src_now[BIT_RX_OVERFLOW]   = rx_overflow_evt;
        src_now[BIT_STAMP_A]       = egress_stamp_a;
        src_now[BIT_STAMP_B]       = egress_stamp_b;
        src_now[BIT_STAMP_C]       = egress_stamp_c;
        src_now[BIT_TX_CHECKSUM]   = tx_checksum_bad;
        set_main                   = src_now & ~c.src_prev & impl;
        set_main[BIT_FRAMING_LOSS] = c.framing_loss_err_sync[1] ^ c.framing_loss_err_sync[2];
        set_main[BIT_HEADER_PARITY] = c.hdr_sync[1] ^ c.hdr_sync[2];
        set_main[BIT_CTRL_PROTECT] = HAS_PROTECT && (c.ctrl_protect_err_sync[1] ^ c.ctrl_protect_err_sync[2]);
    end

    assign clr_main   = (reg_wr && reg_addr == ADDR_STATUS_MAIN) ? reg_wdata[12:0] : 13'h0000;
    assign clr_vendor = (reg_wr && reg_addr == ADDR_VENDOR_STATUS) ? reg_wdata : 32'h0000_0000;
    assign set_vendor = vendor_src & ~c.vsrc_prev;

    // ------------------------------------------------------------
    // device clock domain
    // ------------------------------------------------------------
    // set wins over a clear in the same cycle, so no event is lost
    always_comb begin
        next_c           = c;
        next_c.src_prev  = src_now;
        next_c.vsrc_prev = vendor_src;
        next_c.status    = ((c.status & ~clr_main) | set_main) & impl;
        next_c.status[BIT_PHY_SERVICE] = HAS_PHY_IRQ && phy_service_req;
        next_c.vstatus   = (c.vstatus & ~clr_vendor) | set_vendor;
        if (reg_wr && reg_addr == ADDR_MASK_MAIN) begin
            next_c.mask = reg_wdata[12:0] & MASK_MAIN_WRITABLE;
        end
        if (reg_wr && reg_addr == ADDR_MASK_VENDOR) begin
            next_c.vmask = reg_wdata;
        end
        next_c.tx_credit_count = sat5(tx_credit_raw);
        next_c.rx_chunk_count  = sat5(rx_chunk_raw);
        next_c.prot            = ctrl_protect_enable;
        // reset-done bypasses the masks entirely
        next_c.ext   = next_c.status[BIT_RESET_DONE]
                     | (|(next_c.status & ~next_c.mask & MASK_MAIN_WRITABLE))
                     | (|(next_c.vstatus & ~next_c.vmask));
        next_c.irq_n = ~next_c.ext;
        // link toggles through two flops, third flop only for edge detect
        next_c.hdr_sync  = {c.hdr_sync[1:0], l.hdr_tgl};
        next_c.framing_loss_err_sync = {c.framing_loss_err_sync[1:0], l.framing_loss_err_tgl};
        next_c.ctrl_protect_err_sync = {c.ctrl_protect_err_sync[1:0], l.ctrl_protect_err_tgl};
        // footer word handshake: reload only once the link acknowledged
        next_c.ack_s1 = l.ack;
        next_c.ack_s2 = c.ack_s1;
        if (c.ack_s2 == c.req && c.hold != {c.ext, c.tx_credit_count[4:0], c.rx_chunk_count[4:0]}) begin
            next_c.hold = {c.ext, c.tx_credit_count[4:0], c.rx_chunk_count[4:0]};
            next_c.req  = ~c.req;
        end
        // register reads answer one cycle later; unmapped reads zero
        next_c.rvalid = reg_rd;
        next_c.rdata  = 32'h0000_0000;
        if (reg_rd) begin
            case (reg_addr)
                ADDR_STATUS_MAIN:   next_c.rdata = {19'h00000, c.status};
                ADDR_VENDOR_STATUS: next_c.rdata = c.vstatus;
                ADDR_BUFFER_CREDIT: next_c.rdata = {16'h0000, c.tx_credit_count, c.rx_chunk_count};
                ADDR_MASK_MAIN:     next_c.rdata = {19'h00000, c.mask};
                ADDR_MASK_VENDOR:   next_c.rdata = c.vmask;
                default:            next_c.rdata = 32'h0000_0000;
            endcase
        end
    end

    // register the whole device-side state
    always_ff @(posedge clock) begin
        if (srst) begin
            c         <= '0;
            c.status  <= STATUS_MAIN_RST;
            c.vstatus <= VENDOR_RST;
            c.mask    <= MASK_MAIN_RST;
            c.vmask   <= VMASK_RST;
            c.tx_credit_count <= COUNT_RST;
            c.rx_chunk_count  <= COUNT_RST;
            c.ext     <= 1'b1;
            c.irq_n   <= 1'b0;
        end else begin
            c <= next_c;
        end
    end

    // ------------------------------------------------------------
    // link clock domain
    // ------------------------------------------------------------
    // the link clock may stop between frames; toggles survive that
    assign prot_bad = l.prot_s2 && link_ctrl_valid && (link_ctrl_word != ~link_ctrl_compl);

    always_comb begin
        next_l         = l;
        next_l.req_s1  = c.req;
        next_l.req_s2  = l.req_s1;
        next_l.prot_s1 = c.prot;
        next_l.prot_s2 = l.prot_s1;
        if (l.req_s2 != l.ack) begin
            next_l.footer = c.hold;     // hold is stable while a request is open
            next_l.ack    = l.req_s2;
        end
        if (link_hdr_parity_err) begin
            next_l.hdr_tgl = ~l.hdr_tgl;
        end
        if (link_cs_early_release) begin
            next_l.framing_loss_err_tgl = ~l.framing_loss_err_tgl;
        end
        if (prot_bad) begin
            next_l.ctrl_protect_err_tgl = ~l.ctrl_protect_err_tgl;
        end
        // read words always leave with their complement beside them
        next_l.tx_word  = link_rd_word;
        next_l.tx_compl = ~link_rd_word;
    end

    // register the whole link-side state
    always_ff @(posedge link_clk) begin
        if (link_srst) begin
            l            <= '0;
            l.footer.ext <= 1'b1;
            l.tx_compl   <= 32'hFFFF_FFFF;
        end else begin
            l <= next_l;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign reg_rdata     = c.rdata;
    assign reg_rvalid    = c.rvalid;
    assign irq_out_n     = c.irq_n;
    assign link_footer   = l.footer;
    assign link_tx_word  = l.tx_word;
    assign link_tx_compl = l.tx_compl;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_w1c_clear;
        @(posedge clock) disable iff (srst)
        reg_wr && reg_addr == ADDR_STATUS_MAIN && reg_wdata[BIT_RX_OVERFLOW] && !set_main[BIT_RX_OVERFLOW]
        |=> !c.status[BIT_RX_OVERFLOW];
    endproperty
    a_w1c_clear: assert property (p_w1c_clear) else $error("flag not cleared by write one");

    property p_edge_set;
        @(posedge clock) disable iff (srst)
        tx_proto_evt && !c.src_prev[BIT_TX_PROTO]
        |=> c.status[BIT_TX_PROTO] ##1 (c.status[BIT_TX_PROTO] || $past(clr_main[BIT_TX_PROTO]));
    endproperty
    a_edge_set: assert property (p_edge_set) else $error("edge did not set and hold flag");

    property p_hold;
        @(posedge clock) disable iff (srst)
        c.status[BIT_TX_OVERFLOW] && !clr_main[BIT_TX_OVERFLOW] |=> c.status[BIT_TX_OVERFLOW];
    endproperty
    a_hold: assert property (p_hold) else $error("sticky flag dropped");

    property p_reset_irq;
        @(posedge clock) srst |=> !irq_out_n && c.status[BIT_RESET_DONE] && c.mask == MASK_MAIN_RST;
    endproperty
    a_reset_irq: assert property (p_reset_irq) else $error("reset did not leave interrupt asserted");

    property p_reset_done_ext;
        @(posedge clock) disable iff (srst)
        c.status[BIT_RESET_DONE] |-> !irq_out_n && c.ext;
    endproperty
    a_reset_done_ext: assert property (p_reset_done_ext) else $error("reset done not unmaskable");

    property p_quiet;
        @(posedge clock) disable iff (srst)
        !c.status[BIT_RESET_DONE] && (c.status & ~c.mask & MASK_MAIN_WRITABLE) == 13'h0000
        && (c.vstatus & ~c.vmask) == 32'h0000_0000 |-> irq_out_n && !c.ext;
    endproperty
    a_quiet: assert property (p_quiet) else $error("interrupt with all flags masked");

    property p_credit_sat;
        @(posedge clock) disable iff (srst)
        8'(tx_credit_raw) >= COUNT_SAT |=> c.tx_credit_count == COUNT_SAT;
    endproperty
    a_credit_sat: assert property (p_credit_sat) else $error("credit count not saturated");

    property p_chunk_sat;
        @(posedge clock) disable iff (srst)
        8'(rx_chunk_raw) >= COUNT_SAT |=> c.rx_chunk_count == COUNT_SAT;
    endproperty
    a_chunk_sat: assert property (p_chunk_sat) else $error("chunk count not saturated");

    property p_chunk_pass;
        @(posedge clock) disable iff (srst)
        8'(rx_chunk_raw) < COUNT_SAT |=> c.rx_chunk_count == 8'($past(rx_chunk_raw));
    endproperty
    a_chunk_pass: assert property (p_chunk_pass) else $error("chunk count not passed through");

    property p_mask_slot;
        @(posedge clock) disable iff (srst)
        reg_rd && reg_addr == ADDR_MASK_MAIN |=> reg_rvalid && !reg_rdata[BIT_RESET_DONE];
    endproperty
    a_mask_slot: assert property (p_mask_slot) else $error("reset done mask slot reads one");

    property p_phy_follow;
        @(posedge clock) disable iff (srst)
        ##1 c.status[BIT_PHY_SERVICE] == (HAS_PHY_IRQ && $past(phy_service_req));
    endproperty
    a_phy_follow: assert property (p_phy_follow) else $error("phy flag does not follow request");

    property p_absent;
        @(posedge clock) disable iff (srst)
        (c.status & ~impl) == 13'h0000;
    endproperty
    a_absent: assert property (p_absent) else $error("absent feature flag set");

    property p_vendor_set;
        @(posedge clock) disable iff (srst)
        vendor_src[0] && !c.vsrc_prev[0] |=> c.vstatus[0];
    endproperty
    a_vendor_set: assert property (p_vendor_set) else $error("vendor flag not set");

    property p_prot_toggle;
        @(posedge link_clk) disable iff (link_srst)
        prot_bad |=> l.ctrl_protect_err_tgl != $past(l.ctrl_protect_err_tgl);
    endproperty
    a_prot_toggle: assert property (p_prot_toggle) else $error("protection error not signalled");

    property p_ctrl_protect_err_arrives;
        @(posedge clock) disable iff (srst)
        HAS_PROTECT && (c.ctrl_protect_err_sync[1] ^ c.ctrl_protect_err_sync[2]) |=> c.status[BIT_CTRL_PROTECT];
    endproperty
    a_ctrl_protect_err_arrives: assert property (p_ctrl_protect_err_arrives) else $error("protection flag missed");

    c_clear_write: cover property (@(posedge clock) disable iff (srst)
        c.status[BIT_RESET_DONE] ##1 !c.status[BIT_RESET_DONE]);
    c_unmasked_irq: cover property (@(posedge clock) disable iff (srst)
        !c.status[BIT_RESET_DONE] && !irq_out_n);
    c_set_clear_race: cover property (@(posedge clock) disable iff (srst)
        set_main[BIT_TX_PROTO] && clr_main[BIT_TX_PROTO]);
    c_footer_update: cover property (@(posedge link_clk) disable iff (link_srst)
        l.req_s2 != l.ack);

endmodule

// file: sim/msim_host_model.sv
// host-side link model: link clock, link reset, event strobes, control words
// assumes the bench calls its tasks; the clock rises only while run is set
`timescale 1ns/1ps
module msim_host_model (
    output logic        link_clk,
    output logic        link_srst,
    output logic        link_hdr_parity_err,
    output logic        link_cs_early_release,
    output logic        link_ctrl_valid,
    output logic [31:0] link_ctrl_word,
    output logic [31:0] link_ctrl_compl,
    output logic [31:0] link_rd_word
);
    bit run = 1'b0;
    initial begin
        link_clk = 1'b0;
        {link_srst, link_hdr_parity_err, link_cs_early_release, link_ctrl_valid} = 4'h0;
        link_ctrl_word = 32'hA5A5_0F0F;
        link_ctrl_compl = 32'h0F0F_A5A5;
        link_rd_word = 32'h1234_5678;
    end
    // clock finishes its high phase, then stands still low while the link is idle
    always #7.5 if (run || link_clk) link_clk = ~link_clk;
    // run the link clock for n rising edges, then let it stop
    task automatic burst(input int n);
        run = 1'b1;
        repeat (n) @(posedge link_clk);
        run = 1'b0;
    endtask
    // link reset needs a running clock, so start it first
    task automatic reset_link();
        run = 1'b1;
        @(posedge link_clk);
        link_srst <= 1'b1;
        repeat (4) @(posedge link_clk);
        link_srst <= 1'b0;
        run = 1'b0;
    endtask
    // one strobe: kind 0 header parity, 1 framing loss, 2 control word
    task automatic strobe(input int kind, input bit bad);
        run = 1'b1;
        @(posedge link_clk);
        link_hdr_parity_err <= (kind == 0);
        link_cs_early_release <= (kind == 1);
        link_ctrl_valid <= (kind == 2);
        link_ctrl_compl <= bad ? link_ctrl_word : ~link_ctrl_word;
        @(posedge link_clk);
        {link_hdr_parity_err, link_cs_early_release, link_ctrl_valid} <= 3'h0;
        link_ctrl_word <= ~link_ctrl_word; // stale word must not look valid
        burst(3);
    endtask
endmodule

// file: sim/tb.sv
// self-checking bench of the status, mask and credit block
// assumes the host model drives the link side of the block
`timescale 1ns/1ps
module tb;
    import msim_pkg::*;
    logic         clock = 1'b0;
    logic         srst = 1'b1;
    logic         reg_wr = 1'b0;
    logic         reg_rd = 1'b0;
    logic [7:0]   reg_addr = 8'h00;
    logic [31:0]  reg_wdata = 32'h0;
    logic [7:0]   ev = 8'h00;
    logic         phy = 1'b0;
    logic         prot_en = 1'b1;
    logic [31:0]  vsrc = 32'h0;
    logic [7:0]   credit = 8'h00;
    logic [7:0]   chunk = 8'h00;
    logic [31:0]  reg_rdata, link_ctrl_word, link_ctrl_compl, link_rd_word, tx_w, tx_c;
    logic         reg_rvalid, irq_out_n, link_clk, link_srst;
    logic         link_hdr_parity_err, link_cs_early_release, link_ctrl_valid;
    msim_footer_s footer;
    int           n_errors = 0;
    int           num_checks = 0;
    msim_host_model host (.link_clk, .link_srst, .link_hdr_parity_err, .link_cs_early_release,
        .link_ctrl_valid, .link_ctrl_word, .link_ctrl_compl, .link_rd_word);
    msim_status_irq dut (.clock, .srst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .reg_rvalid,
        .ctrl_protect_enable(prot_en), .tx_checksum_bad(ev[7]), .egress_stamp_a(ev[4]),
        .egress_stamp_b(ev[5]), .egress_stamp_c(ev[6]), .phy_service_req(phy), .rx_overflow_evt(ev[3]),
        .tx_underflow_evt(ev[2]), .tx_overflow_evt(ev[1]), .tx_proto_evt(ev[0]), .vendor_src(vsrc),
        .tx_credit_raw(credit), .rx_chunk_raw(chunk), .irq_out_n, .link_clk, .link_srst,
        .link_hdr_parity_err, .link_cs_early_release, .link_ctrl_valid, .link_ctrl_word,
        .link_ctrl_compl, .link_rd_word, .link_tx_word(tx_w), .link_tx_compl(tx_c), .link_footer(footer));
    // ---------------------------------------------------------------
    // clock, shared tasks
    // ---------------------------------------------------------------
    always #50 clock = ~clock;
    task automatic chk(input logic [35:0] got, input logic [35:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    // read answers on the same edge that takes the strobe
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clock);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1;
        chk({reg_rvalid, reg_rdata}, {1'b1, exp});
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask
    task automatic conclude();
        if (n_errors == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // ---------------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------------
    task automatic t_reset();
        chk(irq_out_n, 1'b0);
        chk(footer, {1'b1, 10'h000});
        rd(ADDR_STATUS_MAIN, 32'h40);
        rd(ADDR_MASK_MAIN, 32'h1FBF);
        rd(ADDR_VENDOR_STATUS, 32'h0);
        rd(ADDR_BUFFER_CREDIT, 32'h0);
        rd(8'h0A, 32'h0);
        wr(ADDR_MASK_MAIN, 32'hFFFF_FFFF);
        rd(ADDR_MASK_MAIN, 32'h1FBF);
        wr(ADDR_STATUS_MAIN, 32'h0);
        rd(ADDR_STATUS_MAIN, 32'h40);
        wr(ADDR_STATUS_MAIN, 32'h40);
        tick(2);
        chk(irq_out_n, 1'b1);
    endtask
    // source held high after the clear must not set the flag again
    task automatic t_events();
        int pos[8] = '{0, 1, 2, 3, 8, 9, 10, 11};
        logic [31:0] b;
        for (int i = 0; i < 8; i++) begin
            b = 32'h1 << pos[i];
            @(posedge clock);
            ev[i] <= 1'b1;
            tick(2);
            chk(irq_out_n, 1'b1);
            rd(ADDR_STATUS_MAIN, b);
            wr(ADDR_MASK_MAIN, 32'h1FBF & ~b);
            tick(2);
            chk(irq_out_n, 1'b0);
            wr(ADDR_STATUS_MAIN, b);
            rd(ADDR_STATUS_MAIN, 32'h0);
            @(posedge clock);
            ev[i] <= 1'b0;
            wr(ADDR_MASK_MAIN, 32'h1FBF);
        end
    endtask
    task automatic t_phy();
        phy <= 1'b1;
        tick(2);
        rd(ADDR_STATUS_MAIN, 32'h80);
        wr(ADDR_STATUS_MAIN, 32'h80);
        rd(ADDR_STATUS_MAIN, 32'h80);
        @(posedge clock);
        phy <= 1'b0;
        tick(2);
        rd(ADDR_STATUS_MAIN, 32'h0);
    endtask
    task automatic t_link();
        logic [31:0] exp[5] = '{32'h20, 32'h10, 32'h1000, 32'h0, 32'h0};
        for (int k = 0; k < 5; k++) begin
            if (k == 4) begin
                prot_en <= 1'b0; // checking off: a bad complement is no error
                tick(2);
                host.burst(4);
            end
            host.strobe(k > 2 ? 2 : k, k == 2 || k == 4);
            tick(8);
            rd(ADDR_STATUS_MAIN, exp[k]);
            wr(ADDR_STATUS_MAIN, exp[k]);
        end
        chk(tx_c ^ tx_w, 32'hFFFF_FFFF);
    endtask
    task automatic t_vendor();
        vsrc <= 32'h8000_0001;
        tick(2);
        chk(irq_out_n, 1'b0);
        rd(ADDR_VENDOR_STATUS, 32'h8000_0001);
        wr(ADDR_MASK_VENDOR, 32'h8000_0001);
        tick(2);
        chk(irq_out_n, 1'b1);
        wr(ADDR_VENDOR_STATUS, 32'h0000_0001);
        rd(ADDR_VENDOR_STATUS, 32'h8000_0000);
        @(posedge clock);
        vsrc <= 32'h0;
    endtask
    // over-range raw counts must clip at 31 in register and footer
    task automatic t_counts();
        credit <= 8'h28;
        chunk <= 8'h07;
        tick(2);
        rd(ADDR_BUFFER_CREDIT, 32'h0000_1F07);
        wr(ADDR_BUFFER_CREDIT, 32'h0);
        chunk <= 8'h20;
        tick(8);
        rd(ADDR_BUFFER_CREDIT, 32'h0000_1F1F);
        host.burst(40);
        chk(irq_out_n, 1'b1);
        chk(footer, {1'b0, 5'h1F, 5'h1F});
    endtask
    // ---------------------------------------------------------------
    // main sequence and watchdog
    // ---------------------------------------------------------------
    initial begin
        host.reset_link();
        repeat (6) @(posedge clock);
        srst <= 1'b0;
        tick(8);
        t_reset();
        t_events();
        t_phy();
        t_link();
        t_vendor();
        t_counts();
        conclude();
    end
    initial begin
        #200000;
        n_errors++;
        conclude();
    end
endmodule
